// [common/timer_five_pkg.sv]
// Shared constants and types for the 24-bit wake-up timer.
// Assumes an 8-bit special-function register port with a 16-bit address.
package timer_five_pkg;

	// ------------------------------------------------------------
	// Widths and register map
	// ------------------------------------------------------------
	localparam int            COUNT_W      = 24;
	localparam int            ADDR_W       = 16;
	localparam int            DATA_W       = 8;
	localparam logic [15:0]   CSR_ADDR     = 16'ha003;
	localparam logic [7:0]    CSR_RESET    = 8'h00;
	localparam logic [23:0]   COUNT_RESET  = 24'h000000;
	localparam logic [23:0]   COUNT_MAX    = 24'hffffff;

	// ------------------------------------------------------------
	// Control/status field positions
	// ------------------------------------------------------------
	localparam int            FLAG_BIT     = 7;
	localparam int            SEL_HI_BIT   = 6;
	localparam int            SEL_LO_BIT   = 5;
	localparam int            MODE_BIT     = 4;
	localparam int            RUN_BIT      = 3;
	localparam int            IEN_BIT      = 0;

	// Clock source codes: high bit clear picks the internal oscillator.
	typedef enum logic [1:0] {
		SRC_INT_A  = 2'b00,
		SRC_INT_B  = 2'b01,
		SRC_SLOW_A = 2'b10,
		SRC_SLOW_B = 2'b11
	} clock_source_t;

	// Control/status fields as stored in the register.
	typedef struct packed {
		logic          timer_five_overflow_flag;
		clock_source_t timer_five_clock_select;
		logic          timer_five_reload_mode_select;
		logic          timer_five_run;
		logic          timer_five_irq_enable;
	} control_t;

	// Register port request.
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} sfr_req_t;

endpackage

// [hdl/source_edge.sv]
// Picks the selected count clock source and marks each rising edge.
// Assumes both oscillator inputs are synchronous to ref_clk.
`timescale 1ns/100ps
module source_edge
	import timer_five_pkg::*;
(
	// Clock and reset
	input  wire logic          ref_clk,
	input  wire logic          rst,
	// Oscillator levels and choice
	input  wire logic          internal_oscillator,
	input  wire logic          slow_oscillator,
	input  wire clock_source_t sel,
	// One-cycle mark per rising edge of the chosen source
	output      logic          tick_r
);

	// ------------------------------------------------------------
	// Source choice and edge detection
	// ------------------------------------------------------------
	logic int_prev_r;
	logic slow_prev_r;
	wire  use_slow;
	wire  int_rise;
	wire  slow_rise;
	wire  tick_nxt;

	// The high select bit alone decides the source.
	assign use_slow  = sel[1];
	assign int_rise  = internal_oscillator & ~int_prev_r;
	assign slow_rise = slow_oscillator & ~slow_prev_r;
	assign tick_nxt  = use_slow ? slow_rise : int_rise;

	// Previous samples and the registered edge mark.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			int_prev_r  <= 1'b0;
			slow_prev_r <= 1'b0;
			tick_r      <= 1'b0;
		end else begin
			int_prev_r  <= internal_oscillator;
			slow_prev_r <= slow_oscillator;
			tick_r      <= tick_nxt;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	source_pick_a: assert property (@(posedge ref_clk) disable iff (rst)
		tick_r |-> ($past(sel[1]) ? $past(slow_oscillator) && !$past(slow_prev_r)
			: $past(internal_oscillator) && !$past(int_prev_r)))
		else $error("Edge mark came from the wrong clock source.");

endmodule

// [hdl/wakeup_timer_24bit.sv]
// 24-bit wake-up timer with one control/status register.
// Assumes register strobes and oscillator levels are synchronous to ref_clk.
//
// What this block does
// - 24-bit counter steps on each source edge.
// - Codes 00/01 internal, 10/11 slow oscillator.
// - Runs free-running or auto-reload.
// - Mode bit 1 reloads, 0 free-runs.
// - Keeps counting in stop or sleep.
// - Overflow gives a wake-up event.
// - Overflow sets flag; only software clears it.
// - Run bit starts and stops counting.
// - Interrupt only when enable bit is set.
// - Register 0xa003 holds flag, select, mode, run, enable.
`timescale 1ns/100ps
module wakeup_timer_24bit
	import timer_five_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Count clock sources
	input  wire logic        internal_oscillator,
	input  wire logic        slow_oscillator,
	// Special-function register port
	input  wire logic [15:0] sfr_addr,
	input  wire logic [7:0]  sfr_wdata,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	output      logic [7:0]  sfr_rdata_r,
	// Reload value and count
	input  wire logic [23:0] reload_value,
	output      logic [23:0] count_r,
	// Events
	output      logic        irq_r,
	output      logic        wake_r
);

	// ------------------------------------------------------------
	// Register port decode
	// ------------------------------------------------------------
	sfr_req_t req;
	control_t ctrl_r;
	control_t ctrl_nxt;
	wire      csr_hit;
	wire      csr_wr;
	wire      csr_rd;
	wire      flag_clear;
	wire [7:0] csr_view;

	// Bundle the port and decode the single register address.
	assign req        = '{addr: sfr_addr, wdata: sfr_wdata, wr: sfr_wr, rd: sfr_rd};
	assign csr_hit    = (req.addr == CSR_ADDR);
	assign csr_wr     = csr_hit & req.wr;
	assign csr_rd     = csr_hit & req.rd;
	assign flag_clear = csr_wr & ~req.wdata[FLAG_BIT]; // Writing 0 clears the flag.
	// Bits 2:1 are unused and read as zero.
	assign csr_view   = {ctrl_r.timer_five_overflow_flag,
		ctrl_r.timer_five_clock_select,
		ctrl_r.timer_five_reload_mode_select,
		ctrl_r.timer_five_run,
		2'b00,
		ctrl_r.timer_five_irq_enable};

	// ------------------------------------------------------------
	// Count clock edges
	// ------------------------------------------------------------
	logic tick_r;

	// Both sources are sampled every cycle, so changing the select while the
	// new source stands high gives no extra edge mark; only a true rise counts.
	source_edge u_source_edge (
		.ref_clk             (ref_clk),
		.rst                 (rst),
		.internal_oscillator (internal_oscillator),
		.slow_oscillator     (slow_oscillator),
		.sel                 (ctrl_r.timer_five_clock_select),
		.tick_r              (tick_r)
	);

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	wire        step;
	wire        overflow;
	wire [23:0] count_nxt;

	// No sleep or stop input gates the step; only run and the source do.
	assign step      = tick_r & ctrl_r.timer_five_run;
	assign overflow  = step & (count_r == COUNT_MAX);
	assign count_nxt = !step ? count_r
		: !overflow ? count_r + 24'h000001
		: ctrl_r.timer_five_reload_mode_select ? reload_value : COUNT_RESET;

	// Counter register.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count_r <= COUNT_RESET;
		end else begin
			count_r <= count_nxt;
		end
	end

	// ------------------------------------------------------------
	// Control/status register
	// ------------------------------------------------------------
	// Spreads a written byte over the stored fields. The flag is passed in
	// unchanged, because a write can only clear it, never set it.
	// Bits 2:1 of the byte fall away here, so they always read as zero.
	function automatic control_t unpack_csr(input logic [7:0] b, input logic flag);
		control_t c;
		c.timer_five_overflow_flag      = flag;
		c.timer_five_clock_select       = clock_source_t'(b[SEL_HI_BIT:SEL_LO_BIT]);
		c.timer_five_reload_mode_select = b[MODE_BIT];
		c.timer_five_run                = b[RUN_BIT];
		c.timer_five_irq_enable         = b[IEN_BIT];
		return c;
	endfunction

	// A write loads the control fields; an overflow in the same cycle as a
	// clearing write still leaves the flag set.
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (csr_wr) begin
			ctrl_nxt = unpack_csr(req.wdata, ctrl_r.timer_five_overflow_flag);
		end
		if (flag_clear) begin
			ctrl_nxt.timer_five_overflow_flag = 1'b0;
		end
		if (overflow) begin
			ctrl_nxt.timer_five_overflow_flag = 1'b1;
		end
	end

	// Register and read data.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_r      <= control_t'({CSR_RESET[FLAG_BIT:RUN_BIT], CSR_RESET[IEN_BIT]});
			sfr_rdata_r <= CSR_RESET;
		end else begin
			ctrl_r      <= ctrl_nxt;
			sfr_rdata_r <= csr_rd ? csr_view : 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Event outputs
	// ------------------------------------------------------------
	wire irq_nxt;
	wire wake_nxt;

	// The interrupt level follows the flag as it will stand after this edge,
	// so it rises with the flag and drops with the clearing write.
	assign irq_nxt  = ctrl_nxt.timer_five_overflow_flag
		& ctrl_nxt.timer_five_irq_enable;
	// One pulse per overflow, whatever the interrupt enable says.
	assign wake_nxt = overflow;

	// Interrupt level and one-cycle wake-up pulse.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq_r  <= 1'b0;
			wake_r <= 1'b0;
		end else begin
			irq_r  <= irq_nxt;
			wake_r <= wake_nxt;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	flag_set_a: assert property (overflow |=> ctrl_r.timer_five_overflow_flag)
		else $error("Overflow did not set the flag.");
	flag_hold_a: assert property (ctrl_r.timer_five_overflow_flag && !flag_clear
		|=> ctrl_r.timer_five_overflow_flag)
		else $error("Flag dropped without a clearing write.");
	count_step_a: assert property (step && !overflow
		|=> count_r == $past(count_r) + 24'h000001)
		else $error("Counter did not step by one.");
	run_stop_a: assert property (!ctrl_r.timer_five_run [*2] |=> $stable(count_r))
		else $error("Counter moved while stopped.");
	reload_load_a: assert property (overflow && ctrl_r.timer_five_reload_mode_select
		|=> count_r == $past(reload_value))
		else $error("Auto-reload did not load the reload value.");
	free_wrap_a: assert property (overflow && !ctrl_r.timer_five_reload_mode_select
		|=> count_r == COUNT_RESET)
		else $error("Free-run overflow did not wrap to zero.");
	irq_gate_a: assert property (irq_r |-> ctrl_r.timer_five_irq_enable
		&& ctrl_r.timer_five_overflow_flag)
		else $error("Interrupt raised without enable and flag.");
	wake_event_a: assert property (overflow |=> wake_r ##1 !wake_r || overflow)
		else $error("Wake-up event missing after overflow.");
	csr_read_a: assert property (csr_rd |=> sfr_rdata_r[2:1] == 2'b00
		&& sfr_rdata_r[FLAG_BIT] == $past(ctrl_r.timer_five_overflow_flag)
		&& sfr_rdata_r[RUN_BIT] == $past(ctrl_r.timer_five_run))
		else $error("Register read returned wrong fields.");

	// Clearing, masking, event, counter-hold and register-port checks.
	flag_clear_a: assert property (flag_clear && !overflow
		|=> !ctrl_r.timer_five_overflow_flag)
		else $error("Clearing write left the flag set.");
	flag_sticky_a: assert property (csr_wr && req.wdata[FLAG_BIT]
		&& !ctrl_r.timer_five_overflow_flag && !overflow
		|=> !ctrl_r.timer_five_overflow_flag)
		else $error("Writing one set the flag.");
	irq_raise_a: assert property (ctrl_r.timer_five_overflow_flag
		&& ctrl_r.timer_five_irq_enable |-> irq_r)
		else $error("Enabled overflow gave no interrupt.");
	wake_cause_a: assert property (wake_r |-> $past(overflow))
		else $error("Wake-up event without an overflow.");
	count_hold_a: assert property (!step |=> $stable(count_r))
		else $error("Counter moved without a step.");
	csr_write_a: assert property (csr_wr
		|=> ctrl_r.timer_five_clock_select == $past(req.wdata[SEL_HI_BIT:SEL_LO_BIT])
		&& ctrl_r.timer_five_reload_mode_select == $past(req.wdata[MODE_BIT])
		&& ctrl_r.timer_five_run == $past(req.wdata[RUN_BIT])
		&& ctrl_r.timer_five_irq_enable == $past(req.wdata[IEN_BIT]))
		else $error("Write did not land in the control fields.");
	read_idle_a: assert property (!csr_rd |=> sfr_rdata_r == 8'h00)
		else $error("Read data not zero outside a read.");

endmodule

// [testbench/tb.sv]
// Self-checking bench for the 24-bit wake-up timer register port and counting.
// Assumes the design package is compiled first; a full 24-bit overflow is too long to reach.
`timescale 1ns/100ps
module tb;
	import timer_five_pkg::*;

	// --------------------------------------------------------
	// Signals
	// --------------------------------------------------------
	logic        ref_clk = 1'b0;
	logic        rst     = 1'b1;
	logic        int_osc = 1'b0;
	logic        slow_osc = 1'b0;
	logic [15:0] sfr_addr = 16'h0000;
	logic [7:0]  sfr_wdata = 8'h00;
	logic        sfr_wr = 1'b0;
	logic        sfr_rd = 1'b0;
	logic [7:0]  sfr_rdata_r;
	logic [23:0] reload_value = 24'h000010;
	logic [23:0] count_r;
	logic        irq_r;
	logic        wake_r;
	logic [23:0] exp_cnt = 24'h000000;
	int          err_total = 0;
	int          check_count = 0;

	// Clock of 40 ns period.
	always #20 ref_clk = ~ref_clk;

	wakeup_timer_24bit wakeup_timer_24bit_i (
		.ref_clk(ref_clk), .rst(rst), .internal_oscillator(int_osc),
		.slow_oscillator(slow_osc), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata_r(sfr_rdata_r),
		.reload_value(reload_value), .count_r(count_r), .irq_r(irq_r), .wake_r(wake_r)
	);

	// --------------------------------------------------------
	// Compare, access and stimulus tasks
	// --------------------------------------------------------
	task automatic summarize;
		if (err_total == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Compares a register byte or single-bit result.
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Compares the count against the bench's own tally.
	task automatic cmp_count(input logic [23:0] exp);
		check_count++;
		if (count_r !== exp) begin
			err_total++;
			$display("MISMATCH %0t count got %h expected %h", $time, count_r, exp);
		end
	endtask

	// One write strobe, held for exactly one taking edge.
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sfr_addr  <= a;
		sfr_wdata <= d;
		sfr_wr    <= 1'b1;
		@(posedge ref_clk);
		sfr_wr <= 1'b0;
	endtask

	// One read strobe; data is registered at the taking edge.
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_rd   <= 1'b1;
		@(posedge ref_clk);
		sfr_rd <= 1'b0;
		#1;
		cmp_byte(sfr_rdata_r, exp, "read");
	endtask

	// Gives n rising edges on one oscillator, spaced three samples apart.
	task automatic pulse(input logic slow, input int n);
		for (int k = 0; k < n; k++) begin
			@(posedge ref_clk);
			if (slow) begin
				slow_osc <= 1'b1;
			end else begin
				int_osc <= 1'b1;
			end
			@(posedge ref_clk);
			slow_osc <= 1'b0;
			int_osc  <= 1'b0;
			@(posedge ref_clk);
		end
		repeat (3) @(posedge ref_clk);
		#1;
	endtask

	// --------------------------------------------------------
	// Tests
	// --------------------------------------------------------
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rd(CSR_ADDR, CSR_RESET);
		cmp_count(24'h000000);
		// Flag written as 1 stays clear; bits 2:1 read zero.
		wr(CSR_ADDR, 8'hff);
		rd(CSR_ADDR, 8'h79);
		// Unmapped place reads zero and its write leaves the register alone.
		wr(16'ha004, 8'h00);
		rd(16'ha004, 8'h00);
		rd(CSR_ADDR, 8'h79);
		// Every source code: only the chosen oscillator advances the count.
		for (int s = 0; s < 4; s++) begin
			wr(CSR_ADDR, {1'b0, s[1:0], 1'b0, 1'b1, 3'b000});
			pulse(1'b0, 2);
			pulse(1'b1, 3);
			exp_cnt = exp_cnt + (s[1] ? 24'h000003 : 24'h000002);
			cmp_count(exp_cnt);
		end
		// Run cleared: edges are ignored.
		wr(CSR_ADDR, 8'h00);
		pulse(1'b0, 2);
		pulse(1'b1, 2);
		cmp_count(exp_cnt);
		// Auto-reload mode with enable counts normally below overflow.
		wr(CSR_ADDR, 8'h19);
		pulse(1'b0, 4);
		cmp_count(exp_cnt + 24'h000004);
		cmp_byte({7'h00, irq_r}, 8'h00, "irq");
		cmp_byte({7'h00, wake_r}, 8'h00, "wake");
		rd(CSR_ADDR, 8'h19);
		// Reset in mid-run returns register, count and events to reset values.
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rd(CSR_ADDR, CSR_RESET);
		cmp_count(COUNT_RESET);
		cmp_byte({7'h00, irq_r}, 8'h00, "irq");
		cmp_byte({7'h00, wake_r}, 8'h00, "wake");
		summarize();
	end

	// Watchdog cuts a hang short.
	initial begin
		repeat (5000) @(posedge ref_clk);
		err_total++;
		summarize();
	end
endmodule
